/* File: shared/pmr_pkg.sv */
package pmr_pkg;
	// clock rate and timing figures
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned DRDY_DELAY_NS  = 10000;
	localparam int unsigned DRDY_WIDTH_NS  = 10000;
	localparam int unsigned STROBE_NS      = 6700;
	localparam int unsigned DIGIT_NS       = 1300000;
	localparam int unsigned DRDY_DELAY_CYC = (DRDY_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DRDY_WIDTH_CYC = (DRDY_WIDTH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned DIGIT_CYC      = (DIGIT_NS * CLK_MHZ) / 1000;
	localparam int unsigned NUM_DIGITS     = 5;

	// conversion thresholds in counts
	localparam int unsigned UNDER_COUNTS = 1800;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;

	// control register field positions
	localparam int unsigned CTRL_BLANK_POS   = 0;
	localparam int unsigned CTRL_DISPEN_POS  = 1;
	localparam int unsigned CTRL_TEST_POS    = 2;
	localparam int unsigned CTRL_POLEN_POS   = 3;
	localparam int unsigned CTRL_HORIZ_POS   = 4;
	localparam int unsigned CTRL_STROKE_POS  = 5;
	localparam int unsigned CTRL_DP_POS      = 8;
	localparam int unsigned CTRL_DESC_POS    = 12;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0002;

	// status register field positions
	localparam int unsigned STAT_BUSY_POS  = 0;
	localparam int unsigned STAT_EOC_POS   = 1;
	localparam int unsigned STAT_OVER_POS  = 2;
	localparam int unsigned STAT_UNDER_POS = 3;
	localparam int unsigned STAT_NEG_POS   = 4;
	localparam int unsigned STAT_BURST_POS = 5;
	localparam int unsigned STAT_DIGIT_POS = 8;

	// result register field positions
	localparam int unsigned RES_NEG_POS  = 20;
	localparam int unsigned RES_OVER_POS = 21;

	// display test pattern, msd first
	localparam logic [19:0] TEST_PATTERN = 20'h1_8888;

	// htrans codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [3:0] desc;
		logic [3:0] dp_sel;
		logic       sign_stroke_control;
		logic       horiz;
		logic       pol_en;
		logic       test;
		logic       disp_en;
		logic       blank;
	} pmr_ctrl_t;

	typedef struct packed {
		logic [19:0] bcd;
		logic        neg;
		logic        over;
	} pmr_result_t;
endpackage

/* File: rtl/pmr_readout.sv */
`timescale 1ns/10ps
module pmr_readout #(
	parameter int unsigned DIGIT_CYC = pmr_pkg::DIGIT_CYC
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_nrst,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// converter side
	input  wire logic        i_sig_integ_start,
	input  wire logic        i_ref_integ_start,
	input  wire logic        i_meas_end,
	input  wire logic        i_result_valid,
	input  wire logic [19:0] i_result_bcd,
	input  wire logic        i_result_neg,
	input  wire logic        i_result_over,
	// display and reader side
	output logic      [4:0]  o_digit_select_lines,
	output logic      [3:0]  o_bcd,
	output logic             o_digit_lit,
	output logic      [3:0]  o_dp_lit,
	output logic             o_sign_horiz_lit,
	output logic             o_sign_vert_lit,
	output logic      [3:0]  o_desc_lit,
	output logic             o_strobe_n,
	output logic             o_data_ready,
	output logic             o_busy,
	output logic             o_eoc,
	output logic             o_overrange,
	output logic             o_below_threshold_flag,
	output logic             o_polarity
);
	localparam int unsigned NUM_DIGITS = pmr_pkg::NUM_DIGITS;
	localparam int unsigned DRDY_DELAY = pmr_pkg::DRDY_DELAY_CYC;
	localparam int unsigned DRDY_WIDTH = pmr_pkg::DRDY_WIDTH_CYC;
	localparam int unsigned STROBE_CYC = pmr_pkg::STROBE_CYC;

	pmr_pkg::pmr_ctrl_t   ctrl_ff;
	pmr_pkg::pmr_ctrl_t   nxt_ctrl;
	pmr_pkg::pmr_result_t result_ff;
	logic                 wr_pend_ff;
	logic [7:0]           wr_addr_ff;
	logic [31:0]          nxt_rdata;
	logic [7:0]           addr_lo;
	logic                 addr_ok;
	logic [19:0]          scan_cnt_ff;
	logic [2:0]           digit_idx_ff;
	logic                 slot_end;
	logic                 burst_pend_ff;
	logic                 burst_ff;
	logic                 drdy_busy_ff;
	logic [11:0]          drdy_cnt_ff;
	logic                 conv_ff;
	logic [16:0]          bin_val;
	logic [19:0]          shown_bcd;
	logic [3:0]           cur_digit;
	logic                 msd_slot_start;

	// address phase qualifier
	assign addr_ok = i_hsel & i_hready & (i_htrans == pmr_pkg::HTRANS_NONSEQ);
	assign addr_lo = i_haddr[7:0];

	// write of the control register lands in the data phase
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_pend_ff && wr_addr_ff == pmr_pkg::OFS_CTRL) begin
			nxt_ctrl.blank   = i_hwdata[pmr_pkg::CTRL_BLANK_POS];
			nxt_ctrl.disp_en = i_hwdata[pmr_pkg::CTRL_DISPEN_POS];
			nxt_ctrl.test    = i_hwdata[pmr_pkg::CTRL_TEST_POS];
			nxt_ctrl.pol_en  = i_hwdata[pmr_pkg::CTRL_POLEN_POS];
			nxt_ctrl.horiz   = i_hwdata[pmr_pkg::CTRL_HORIZ_POS];
			nxt_ctrl.sign_stroke_control = i_hwdata[pmr_pkg::CTRL_STROKE_POS];
			nxt_ctrl.dp_sel  = i_hwdata[pmr_pkg::CTRL_DP_POS +: 4];
			nxt_ctrl.desc    = i_hwdata[pmr_pkg::CTRL_DESC_POS +: 4];
		end
	end

	// read mux, taken at the end of the address phase
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (addr_lo == pmr_pkg::OFS_CTRL) begin
			nxt_rdata[pmr_pkg::CTRL_BLANK_POS]  = nxt_ctrl.blank;
			nxt_rdata[pmr_pkg::CTRL_DISPEN_POS] = nxt_ctrl.disp_en;
			nxt_rdata[pmr_pkg::CTRL_TEST_POS]   = nxt_ctrl.test;
			nxt_rdata[pmr_pkg::CTRL_POLEN_POS]  = nxt_ctrl.pol_en;
			nxt_rdata[pmr_pkg::CTRL_HORIZ_POS]  = nxt_ctrl.horiz;
			nxt_rdata[pmr_pkg::CTRL_STROKE_POS] = nxt_ctrl.sign_stroke_control;
			nxt_rdata[pmr_pkg::CTRL_DP_POS +: 4]   = nxt_ctrl.dp_sel;
			nxt_rdata[pmr_pkg::CTRL_DESC_POS +: 4] = nxt_ctrl.desc;
		end else if (addr_lo == pmr_pkg::OFS_STATUS) begin
			nxt_rdata[pmr_pkg::STAT_BUSY_POS]  = o_busy;
			nxt_rdata[pmr_pkg::STAT_EOC_POS]   = o_eoc;
			nxt_rdata[pmr_pkg::STAT_OVER_POS]  = o_overrange;
			nxt_rdata[pmr_pkg::STAT_UNDER_POS] = o_below_threshold_flag;
			nxt_rdata[pmr_pkg::STAT_NEG_POS]   = o_polarity;
			nxt_rdata[pmr_pkg::STAT_BURST_POS] = burst_ff;
			nxt_rdata[pmr_pkg::STAT_DIGIT_POS +: 3] = digit_idx_ff;
		end else if (addr_lo == pmr_pkg::OFS_RESULT) begin
			nxt_rdata[19:0] = result_ff.bcd;
			nxt_rdata[pmr_pkg::RES_NEG_POS]  = result_ff.neg;
			nxt_rdata[pmr_pkg::RES_OVER_POS] = result_ff.over;
		end
	end

	// bus slave: zero wait states, always okay
	// hsize is not decoded: word access only
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_pend_ff  <= 1'b0;
			wr_addr_ff  <= 8'h00;
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend_ff  <= addr_ok & i_hwrite & (i_haddr[31:8] == 24'h00_0000);
			wr_addr_ff  <= addr_lo;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			if (addr_ok && !i_hwrite) begin
				o_hrdata <= (i_haddr[31:8] == 24'h00_0000) ? nxt_rdata : 32'h0000_0000;
			end
		end
	end

	// control register
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_ff <= pmr_pkg::pmr_ctrl_t'(pmr_pkg::CTRL_RESET[13:0]);
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// latch each new conversion result
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			result_ff <= '0;
		end else if (i_result_valid) begin
			result_ff.bcd  <= i_result_bcd;
			result_ff.neg  <= i_result_neg;
			result_ff.over <= i_result_over;
		end
	end

	// binary weight of the incoming bcd count
	always_comb begin
		bin_val = 17'(i_result_bcd[19:16]) * 17'd10000
			+ 17'(i_result_bcd[15:12]) * 17'd1000
			+ 17'(i_result_bcd[11:8]) * 17'd100
			+ 17'(i_result_bcd[7:4]) * 17'd10
			+ 17'(i_result_bcd[3:0]);
	end

	// overrange flag: set on latch beats the phase clear
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_overrange <= 1'b0;
		end else if (i_result_valid && i_result_over) begin
			o_overrange <= 1'b1;
		end else if (i_ref_integ_start) begin
			o_overrange <= 1'b0;
		end
	end

	// underrange flag
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_below_threshold_flag <= 1'b0;
		end else if (i_result_valid && !i_result_over
			&& bin_val <= 17'(pmr_pkg::UNDER_COUNTS)) begin
			o_below_threshold_flag <= 1'b1;
		end else if (i_sig_integ_start) begin
			o_below_threshold_flag <= 1'b0;
		end
	end

	// conversion in progress, ends at the latch
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			conv_ff <= 1'b0;
			o_eoc   <= 1'b0;
		end else begin
			if (i_sig_integ_start) begin
				conv_ff <= 1'b1;
				o_eoc   <= 1'b1;
			end else if (i_result_valid) begin
				conv_ff <= 1'b0;
				o_eoc   <= 1'b0;
			end
		end
	end

	// busy stretches to measurement end after an overrange
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_busy <= 1'b0;
		end else if (i_sig_integ_start) begin
			o_busy <= 1'b1;
		end else if (i_result_valid && !i_result_over) begin
			o_busy <= 1'b0;
		end else if (i_meas_end && !conv_ff) begin
			o_busy <= 1'b0;
		end
	end

	// polarity output follows the latched sign
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_polarity <= 1'b0;
		end else begin
			o_polarity <= result_ff.neg;
		end
	end

	// data-ready: delay then pulse, restarted by each latch
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			drdy_busy_ff <= 1'b0;
			drdy_cnt_ff  <= 12'h000;
			o_data_ready <= 1'b0;
		end else if (i_result_valid) begin
			drdy_busy_ff <= 1'b1;
			drdy_cnt_ff  <= 12'h000;
			o_data_ready <= 1'b0;
		end else if (drdy_busy_ff) begin
			drdy_cnt_ff <= drdy_cnt_ff + 12'h001;
			if (drdy_cnt_ff == 12'(DRDY_DELAY - 1)) begin
				o_data_ready <= 1'b1;
			end else if (drdy_cnt_ff == 12'(DRDY_DELAY + DRDY_WIDTH - 1)) begin
				o_data_ready <= 1'b0;
				drdy_busy_ff <= 1'b0;
			end
		end
	end

	// digit slot timer
	assign slot_end = (scan_cnt_ff == 20'(DIGIT_CYC - 1));

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scan_cnt_ff <= 20'h0_0000;
		end else if (slot_end) begin
			scan_cnt_ff <= 20'h0_0000;
		end else begin
			scan_cnt_ff <= scan_cnt_ff + 20'h0_0001;
		end
	end

	// digit index walks msd (4) down to lsd (0)
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			digit_idx_ff <= 3'(NUM_DIGITS - 1);
		end else if (slot_end) begin
			if (digit_idx_ff == 3'h0) begin
				digit_idx_ff <= 3'(NUM_DIGITS - 1);
			end else begin
				digit_idx_ff <= digit_idx_ff - 3'h1;
			end
		end
	end

	// one-hot select lines, one slot per digit
	genvar g;
	generate
		for (g = 0; g < NUM_DIGITS; g++) begin : g_sel
			always_ff @(posedge i_sys_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					o_digit_select_lines[g] <= 1'b0;
				end else begin
					o_digit_select_lines[g] <= (digit_idx_ff == 3'(g));
				end
			end
		end
	endgenerate

	// value shown: test pattern or the latched reading
	always_comb begin
		shown_bcd = result_ff.bcd;
		if (ctrl_ff.test) begin
			shown_bcd = pmr_pkg::TEST_PATTERN;
		end
	end

	assign cur_digit = shown_bcd[{digit_idx_ff, 2'b00} +: 4];

	// shared bcd lines carry the active digit
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_bcd <= 4'h0;
		end else begin
			o_bcd <= cur_digit;
		end
	end

	// burst waits for the next msd slot
	assign msd_slot_start = slot_end && (digit_idx_ff == 3'h0);

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			burst_pend_ff <= 1'b0;
			burst_ff      <= 1'b0;
		end else begin
			if (i_result_valid) begin
				burst_pend_ff <= 1'b1;
			end else if (msd_slot_start) begin
				burst_pend_ff <= 1'b0;
			end
			// a new latch cancels a burst in flight so no
			// stale digit is strobed after the result changes
			if (i_result_valid) begin
				burst_ff <= 1'b0;
			end else if (msd_slot_start) begin
				burst_ff <= burst_pend_ff;
			end
		end
	end

	// strobe low at the head of each slot of the burst
	// the reader takes o_bcd while strobe is low
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_strobe_n <= 1'b1;
		end else begin
			o_strobe_n <= ~(burst_ff && !i_result_valid
				&& scan_cnt_ff < 20'(STROBE_CYC));
		end
	end

	// display lighting: digits, points, sign, labels
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_digit_lit      <= 1'b0;
			o_dp_lit         <= 4'h0;
			o_sign_horiz_lit <= 1'b0;
			o_sign_vert_lit  <= 1'b0;
			o_desc_lit       <= 4'h0;
		end else begin
			o_digit_lit <= ctrl_ff.disp_en & (~ctrl_ff.blank | ctrl_ff.test);
			o_dp_lit    <= ctrl_ff.dp_sel & {4{ctrl_ff.disp_en}};
			o_sign_horiz_lit <= ctrl_ff.disp_en & (ctrl_ff.pol_en | ctrl_ff.horiz);
			o_sign_vert_lit  <= ctrl_ff.disp_en & ~result_ff.neg
				& (ctrl_ff.pol_en | (ctrl_ff.horiz & ctrl_ff.sign_stroke_control));
			o_desc_lit  <= ctrl_ff.desc & {4{ctrl_ff.disp_en}};
		end
	end
endmodule // pmr_readout

/* File: testbench/pmr_readout_checker.sv */
`timescale 1ns/10ps
// port-level checks of the digit readout
module pmr_readout_checker #(
	parameter int unsigned DIGIT_CYC = pmr_pkg::DIGIT_CYC
) (
	input wire logic        i_sys_clk,
	input wire logic        i_nrst,
	input wire logic        i_sig_integ_start,
	input wire logic        i_ref_integ_start,
	input wire logic        i_result_valid,
	input wire logic [19:0] i_result_bcd,
	input wire logic        i_result_over,
	input wire logic [4:0]  o_digit_select_lines,
	input wire logic        o_strobe_n,
	input wire logic        o_data_ready,
	input wire logic        o_busy,
	input wire logic        o_eoc,
	input wire logic        o_overrange,
	input wire logic        o_below_threshold_flag
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_nrst);
	logic [15:0] lo_cnt_ff;
	logic [15:0] hi_cnt_ff;
	logic [4:0]  sel_q_ff;
	logic [19:0] slot_cnt_ff;
	// length of each digit-select slot
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sel_q_ff    <= 5'h00;
			slot_cnt_ff <= 20'h0_0000;
		end else begin
			sel_q_ff    <= o_digit_select_lines;
			slot_cnt_ff <= (o_digit_select_lines != sel_q_ff) ? 20'h0_0001
				: slot_cnt_ff + 20'h0_0001;
		end
	end
	// low time of strobe, high time of data ready
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lo_cnt_ff <= 16'h0;
			hi_cnt_ff <= 16'h0;
		end else begin
			lo_cnt_ff <= o_strobe_n ? 16'h0 : lo_cnt_ff + 16'h1;
			hi_cnt_ff <= o_data_ready ? hi_cnt_ff + 16'h1 : 16'h0;
		end
	end
	property p_over;
		i_result_valid && i_result_over |=> o_overrange && !o_below_threshold_flag;
	endproperty
	a_over: assert property (p_over) else $error("overrange not set");
	property p_over_clr;
		i_ref_integ_start && !i_result_valid |=> !o_overrange;
	endproperty
	a_over_clr: assert property (p_over_clr) else $error("overrange kept");
	property p_under;
		i_result_valid && !i_result_over && (i_result_bcd <= 20'h01800)
			|=> o_below_threshold_flag;
	endproperty
	a_under: assert property (p_under) else $error("underrange not set");
	property p_under_clr;
		i_sig_integ_start && !i_result_valid |=> !o_below_threshold_flag;
	endproperty
	a_under_clr: assert property (p_under_clr) else $error("underrange kept");
	property p_busy;
		i_sig_integ_start && !i_result_valid |=> o_busy && o_eoc;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set");
	property p_done;
		i_result_valid && !i_result_over |=> !o_busy && !o_eoc;
	endproperty
	a_done: assert property (p_done) else $error("busy not cleared");
	property p_scan;
		!o_strobe_n |-> $onehot(o_digit_select_lines);
	endproperty
	a_scan: assert property (p_scan) else $error("select not one-hot");
	property p_strobe_w;
		$rose(o_strobe_n) |-> lo_cnt_ff == pmr_pkg::STROBE_CYC;
	endproperty
	a_strobe_w: assert property (p_strobe_w) else $error("strobe width");
	property p_drdy_w;
		$fell(o_data_ready) |-> hi_cnt_ff == pmr_pkg::DRDY_WIDTH_CYC;
	endproperty
	a_drdy_w: assert property (p_drdy_w) else $error("data ready width");
	property p_slot;
		(o_digit_select_lines != sel_q_ff) && (sel_q_ff != 5'h00) |-> slot_cnt_ff == DIGIT_CYC;
	endproperty
	a_slot: assert property (p_slot) else $error("digit slot length");
endmodule // pmr_readout_checker

bind pmr_readout pmr_readout_checker #(.DIGIT_CYC(DIGIT_CYC)) u_pmr_readout_checker (
	.i_sys_clk, .i_nrst, .i_sig_integ_start, .i_ref_integ_start, .i_result_valid,
	.i_result_bcd, .i_result_over, .o_digit_select_lines, .o_strobe_n, .o_data_ready,
	.o_busy, .o_eoc, .o_overrange, .o_below_threshold_flag
);

/* File: testbench/pmr_reader_model.sv */
`timescale 1ns/10ps
// external reader, takes one digit per strobe
module pmr_reader_model (
	input wire logic       i_sys_clk,
	input wire logic       i_strobe_n,
	input wire logic [3:0] i_bcd,
	input wire logic [4:0] i_digit_select_lines
);
	logic [8:0] got_q[$];
	int         lo_cnt = 0;
	// capture well inside the low strobe
	always @(posedge i_sys_clk) begin
		lo_cnt = i_strobe_n ? 0 : lo_cnt + 1;
		if (lo_cnt == 8) got_q.push_back({i_digit_select_lines, i_bcd});
	end
endmodule // pmr_reader_model

/* File: testbench/tb.sv */
`timescale 1ns/10ps
// self-checking bench of the digit readout
module tb;
	localparam int unsigned DCYC = 1400;
	logic        i_sys_clk, i_nrst, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
	logic [31:0] i_haddr, i_hwdata, o_hrdata, v;
	logic [1:0]  i_htrans;
	logic [2:0]  i_hsize;
	logic        i_sig_integ_start, i_ref_integ_start, i_meas_end, i_result_valid;
	logic        i_result_neg, i_result_over, o_digit_lit, o_sign_horiz_lit, o_sign_vert_lit;
	logic        o_strobe_n, o_data_ready, o_busy, o_eoc, o_overrange;
	logic        o_below_threshold_flag, o_polarity;
	logic [19:0] i_result_bcd, b;
	logic [4:0]  o_digit_select_lines;
	logic [3:0]  o_bcd, o_dp_lit, o_desc_lit;
	int          error_cnt, n_tests, exp_q, n, k;
	int          cyc = 0;
	assign i_hready = o_hreadyout;
	pmr_readout #(.DIGIT_CYC(DCYC)) u_pmr_readout (
		.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
		.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
		.i_sig_integ_start(i_sig_integ_start), .i_ref_integ_start(i_ref_integ_start),
		.i_meas_end(i_meas_end), .i_result_valid(i_result_valid),
		.i_result_bcd(i_result_bcd), .i_result_neg(i_result_neg),
		.i_result_over(i_result_over), .o_digit_select_lines(o_digit_select_lines),
		.o_bcd(o_bcd), .o_digit_lit(o_digit_lit), .o_dp_lit(o_dp_lit),
		.o_sign_horiz_lit(o_sign_horiz_lit), .o_sign_vert_lit(o_sign_vert_lit),
		.o_desc_lit(o_desc_lit), .o_strobe_n(o_strobe_n), .o_data_ready(o_data_ready),
		.o_busy(o_busy), .o_eoc(o_eoc), .o_overrange(o_overrange),
		.o_below_threshold_flag(o_below_threshold_flag), .o_polarity(o_polarity));
	pmr_reader_model u_pmr_reader_model (.i_sys_clk(i_sys_clk), .i_strobe_n(o_strobe_n),
		.i_bcd(o_bcd), .i_digit_select_lines(o_digit_select_lines));
	// clock
	initial begin
		i_sys_clk = 1'h0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end
	task automatic close_out();
		$display("mismatches %0d of %0d checks", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// single ahb-lite transfer, waits on hready
	task automatic ahb(input logic we, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge i_sys_clk);
		i_hsel <= 1'h1;
		i_haddr <= a;
		i_hwrite <= we;
		i_htrans <= pmr_pkg::HTRANS_NONSEQ;
		@(posedge i_sys_clk);
		while (o_hreadyout !== 1'h1) @(posedge i_sys_clk);
		i_hsel <= 1'h0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		@(posedge i_sys_clk);
		while (o_hreadyout !== 1'h1) @(posedge i_sys_clk);
		rd = o_hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'h1, a, d, x);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
		logic [31:0] x;
		ahb(1'h0, a, 32'h0, x);
		chk(nm, x, e);
		chk("resp", {o_hreadyout, o_hresp}, 32'h2);
	endtask
	task automatic wt_sel(input logic [4:0] s);
		while (o_digit_select_lines !== s) @(negedge i_sys_clk);
	endtask
	// one measurement cycle with its expected outcome
	task automatic conv(input logic [19:0] bv, input logic ng, input logic ov);
		int val;
		val = 0;
		for (k = 4; k >= 0; k--) val = val * 10 + bv[4*k+:4];
		chk("burst count", u_pmr_reader_model.got_q.size(), exp_q);
		@(posedge i_sys_clk);
		i_sig_integ_start <= 1'h1;
		@(posedge i_sys_clk);
		i_sig_integ_start <= 1'h0;
		@(negedge i_sys_clk);
		chk("under clr", o_below_threshold_flag, 32'h0);
		chk("busy eoc", {o_busy, o_eoc}, 32'h3);
		@(posedge i_sys_clk);
		i_ref_integ_start <= 1'h1;
		@(posedge i_sys_clk);
		i_ref_integ_start <= 1'h0;
		@(negedge i_sys_clk);
		chk("over clr", o_overrange, 32'h0);
		@(posedge i_sys_clk);
		{i_result_valid, i_result_bcd, i_result_neg, i_result_over} <= {1'h1, bv, ng, ov};
		@(posedge i_sys_clk);
		i_result_valid <= 1'h0;
		u_pmr_reader_model.got_q.delete();
		@(negedge i_sys_clk);
		chk("over", o_overrange, ov);
		chk("under", o_below_threshold_flag, !ov && val <= 1800);
		chk("busy end", {o_busy, o_eoc}, {ov, 1'h0});
		for (n = 1; o_data_ready !== 1'h1; n++) @(negedge i_sys_clk);
		chk("drdy delay", n >= 1990 && n <= 2010, 32'h1);
		chk("polarity", o_polarity, ng);
		chk("sign", {o_sign_horiz_lit, o_sign_vert_lit}, {1'h1, !ng});
		chk("blanked", {o_digit_lit, o_dp_lit}, 32'h5);
		for (n = 0; o_data_ready === 1'h1; n++) @(negedge i_sys_clk);
		chk("drdy width", n, pmr_pkg::DRDY_WIDTH_CYC);
		if (ov) begin
			chk("busy hold", o_busy, 32'h1);
			@(posedge i_sys_clk);
			i_meas_end <= 1'h1;
			@(posedge i_sys_clk);
			i_meas_end <= 1'h0;
			@(negedge i_sys_clk);
			chk("busy drop", o_busy, 32'h0);
		end
		rdc("result", pmr_pkg::OFS_RESULT, {10'h0, ov, ng, bv});
		while (u_pmr_reader_model.got_q.size() < 5) @(negedge i_sys_clk);
		for (k = 0; k < 5; k++) begin
			chk("digit", u_pmr_reader_model.got_q[k], {5'h10 >> k, bv[4*(4-k)+:4]});
		end
		// let the last strobe end before the next latch
		while (o_strobe_n !== 1'h1) @(negedge i_sys_clk);
		exp_q = 5;
	endtask
	// main sequence
	initial begin
		{i_nrst, i_hsel, i_hwrite, i_sig_integ_start, i_ref_integ_start} = 5'h0;
		{i_meas_end, i_result_valid, i_result_neg, i_result_over, i_htrans} = 6'h0;
		{i_haddr, i_hwdata, i_result_bcd} = 84'h0;
		i_hsize = 3'h2;
		error_cnt = 0;
		n_tests = 0;
		exp_q = 0;
		v = $urandom(84);
		repeat (4) @(posedge i_sys_clk);
		i_nrst <= 1'h1;
		// reset values and refused writes
		rdc("ctrl reset", pmr_pkg::OFS_CTRL, pmr_pkg::CTRL_RESET);
		wr(pmr_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		wr(32'h0000_000C, 32'hFFFF_FFFF);
		rdc("unmapped", 32'h0000_000C, 32'h0);
		ahb(1'h0, pmr_pkg::OFS_STATUS, 32'h0, v);
		chk("status", v & 32'h0000_00FF, 32'h0);
		// blank, enable and test combinations
		for (int i = 0; i < 8; i++) begin
			v = ($urandom & 32'h0000_FF30) | i;
			wr(pmr_pkg::OFS_CTRL, v);
			rdc("ctrl", pmr_pkg::OFS_CTRL, v);
			@(negedge i_sys_clk);
			chk("digit lit", o_digit_lit, v[1] & (!v[0] | v[2]));
			chk("labels", {o_desc_lit, o_dp_lit}, v[15:8] & {8{v[1]}});
			k = v[1] & v[4];
			chk("sign", {o_sign_horiz_lit, o_sign_vert_lit}, {k[0], k[0] & v[5]});
		end
		// test pattern over the whole scan
		wr(pmr_pkg::OFS_CTRL, 32'h0000_0007);
		wt_sel(5'h02);
		for (k = 4; k >= 0; k--) begin
			wt_sel(5'h01 << k);
			chk("pattern", o_bcd, pmr_pkg::TEST_PATTERN[4*k+:4]);
		end
		for (n = 0; o_digit_select_lines === 5'h01; n++) @(negedge i_sys_clk);
		chk("slot", n, DCYC);
		// conversions, display blanked with sign and points kept
		wr(pmr_pkg::OFS_CTRL, 32'h0000_053B);
		conv(20'h20000, 1'h0, 1'h1);
		conv(20'h01800, 1'h1, 1'h0);
		conv(20'h00000, 1'h1, 1'h0);
		for (k = 0; k < 4; k++) b[4*k+:4] = 4'($urandom % 10);
		b[19:16] = 4'h1;
		conv(b, 1'($urandom), 1'h0);
		// second reset in mid-run
		wr(pmr_pkg::OFS_CTRL, 32'h0000_0000);
		@(posedge i_sys_clk);
		i_nrst <= 1'h0;
		@(posedge i_sys_clk);
		i_nrst <= 1'h1;
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		chk("after reset", {o_digit_select_lines, o_strobe_n, o_data_ready}, 32'h42);
		rdc("ctrl again", pmr_pkg::OFS_CTRL, pmr_pkg::CTRL_RESET);
		close_out();
	end
endmodule // tb
